//--- verilog/fis_defines.vh
// Register map, field positions, reset values and timing counts of the scanner
`ifndef FIS_DEFINES_VH
`define FIS_DEFINES_VH

`define FIS_IDX_MAIN_CTRL 10'h000
`define FIS_IDX_SRC_MODE 10'h001
`define FIS_IDX_RESULT 10'h002
`define FIS_IDX_INT_STATUS 10'h003
`define FIS_IDX_INT_MASK 10'h004

`define FIS_BIT_EN 0
`define FIS_BIT_NONMASKABLE_TRIGGER_ENABLE 1
`define FIS_BIT_STROBE_RST 7
`define FIS_SEC_LSB 0
`define FIS_SEC_MSB 1
`define FIS_MODE_LSB 4
`define FIS_MODE_MSB 5
`define FIS_BIT_BUSY 0
`define FIS_BIT_OK 1
`define FIS_INT_DONE 0
`define FIS_INT_FAIL 1

`define FIS_RST_SRC_MODE 8'h00
`define FIS_RST_RESULT 8'h02
`define FIS_MODE_PRIORITY 2'h0
`define FIS_MODE_FROM_BOOT 2'h1
`define FIS_SEC_FULL 2'h0
`define FIS_SEC_BOOT_APP 2'h1
`define FIS_SEC_BOOT 2'h2
`define FIS_SEC_RESERVED 2'h3

`define FIS_START_DELAY 2'h3
`define FIS_FETCH_PERIOD 3
`define FIS_CRC_POLY 16'h1021
`define FIS_CRC_INIT 16'hffff

`endif

//--- verilog/fis_crc16.v
// One-word-per-step CRC-16 accumulator
`default_nettype none
`include "fis_defines.vh"

module fis_crc16 #(
	parameter [15:0] POLY = `FIS_CRC_POLY,
	parameter [15:0] INIT = `FIS_CRC_INIT
)(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control and data
	input wire clear,
	input wire step,
	input wire [15:0] word,
	// Running value
	output reg [15:0] crc
);

	reg [15:0] next_crc;
	integer i;

	always @*
	begin
		next_crc = crc;
		for (i = 15; i >= 0; i = i - 1)
		begin
			if (next_crc[15] ^ word[i])
				next_crc = {next_crc[14:0], 1'b0} ^ POLY;
			else
				next_crc = {next_crc[14:0], 1'b0};
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			crc <= 16'hffff;
		else if (clear)
			crc <= INIT;
		else if (step)
			crc <= next_crc;
	end

endmodule

`default_nettype wire

//--- verilog/fis_divider.v
// Free phase counter that paces flash fetches while running
`default_nettype none
`include "fis_defines.vh"

module fis_divider #(
	parameter N = `FIS_FETCH_PERIOD,
	parameter W = 2
)(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Run gate; phase restarts at zero whenever it is low
	input wire run,
	output reg [W-1:0] phase
);

	localparam integer LAST_I = N - 1;
	localparam [W-1:0] LAST = LAST_I[W-1:0];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= {W{1'b0}};
		else if (!run || phase == LAST)
			phase <= {W{1'b0}};
		else
			phase <= phase + {{(W-1){1'b0}}, 1'b1};
	end

endmodule

`default_nettype wire

//--- verilog/fis_flash_integrity_scanner.v
// Flash integrity scanner: APB registers, start sequencing, fetch pacing, result and NMI
`default_nettype none
`include "fis_defines.vh"

module fis_flash_integrity_scanner #(
	parameter AW = 15
)(
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Flash array, one-cycle read latency
	output reg flash_rd,
	output reg [AW-1:0] flash_addr,
	input wire [15:0] flash_rdata,
	// Last word address of each section
	input wire [AW-1:0] boot_last_word,
	input wire [AW-1:0] app_last_word,
	input wire [AW-1:0] flash_last_word,
	// Reset-time scan configuration
	input wire boot_scan_en,
	input wire [1:0] boot_scan_src,
	// System side
	output wire cpu_halt,
	output reg nmi_req,
	output wire irq
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_DELAY = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	localparam [1:0] PH_ISSUE = 2'h0;
	localparam [1:0] PH_TAKE = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// State

	reg [1:0] state, delay_cnt, access_mode, flash_section_select, int_status, int_mask;
	reg scan_en, nonmaskable_trigger_enable, pass_flag, strobe_pending, init_pending;
	reg ev_done, ev_fail, crc_clear, crc_step;
	reg [AW-1:0] last_addr;
	wire [1:0] phase, int_events, int_clear;
	wire [15:0] crc_value;
	wire busy, start_ok, locked;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire [9:0] reg_idx;
	wire mapped, setup, access, wr, wr_main, wr_src, wr_int_st, wr_mask;
	reg [7:0] rd_value;

	assign reg_idx = paddr[11:2];
	assign mapped = (paddr[1:0] == 2'h0) && (reg_idx <= `FIS_IDX_INT_MASK);
	assign setup = psel && !penable;
	assign access = psel && penable;
	// Zero wait states; only the low byte lane holds register bits
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign wr = access && pwrite && mapped && pstrb[0];
	assign wr_main = wr && (reg_idx == `FIS_IDX_MAIN_CTRL);
	assign wr_src = wr && (reg_idx == `FIS_IDX_SRC_MODE);
	assign wr_int_st = wr && (reg_idx == `FIS_IDX_INT_STATUS);
	assign wr_mask = wr && (reg_idx == `FIS_IDX_INT_MASK);

	assign busy = (state == ST_RUN);
	assign cpu_halt = busy;
	assign irq = |(int_status & int_mask);

	always @*
	begin
		rd_value = 8'h00;
		case (reg_idx)
			`FIS_IDX_MAIN_CTRL:
			begin
				rd_value[`FIS_BIT_EN] = scan_en;
				rd_value[`FIS_BIT_NONMASKABLE_TRIGGER_ENABLE] = nonmaskable_trigger_enable;
			end
			`FIS_IDX_SRC_MODE:
			begin
				rd_value[`FIS_MODE_MSB:`FIS_MODE_LSB] = access_mode;
				rd_value[`FIS_SEC_MSB:`FIS_SEC_LSB] = flash_section_select;
			end
			`FIS_IDX_RESULT:
			begin
				rd_value[`FIS_BIT_BUSY] = busy;
				rd_value[`FIS_BIT_OK] = pass_flag && !busy;
			end
			`FIS_IDX_INT_STATUS:
				rd_value[1:0] = int_status;
			`FIS_IDX_INT_MASK:
				rd_value[1:0] = int_mask;
			default:
				rd_value = 8'h00;
		endcase
	end

	// Read data is captured in the setup cycle so it is stable for the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup && !pwrite)
			prdata <= {24'h000000, rd_value};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Section end selection

	always @*
	begin
		case (flash_section_select)
			`FIS_SEC_FULL:
				last_addr = flash_last_word;
			`FIS_SEC_BOOT_APP:
				last_addr = app_last_word;
			`FIS_SEC_BOOT:
				last_addr = boot_last_word;
			default:
				last_addr = flash_last_word;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, sequencing and result

	assign start_ok = (access_mode == `FIS_MODE_PRIORITY) &&
		(flash_section_select != `FIS_SEC_RESERVED);
	// After an NMI the control and source registers refuse writes; interrupt registers do not
	assign locked = nmi_req;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			delay_cnt <= 2'h0;
			scan_en <= 1'b0;
			nonmaskable_trigger_enable <= 1'b0;
			access_mode <= 2'h0;
			flash_section_select <= 2'h0;
			pass_flag <= 1'b1;
			strobe_pending <= 1'b0;
			init_pending <= 1'b1;
			nmi_req <= 1'b0;
			flash_rd <= 1'b0;
			flash_addr <= {AW{1'b0}};
			ev_done <= 1'b0;
			ev_fail <= 1'b0;
			crc_clear <= 1'b0;
			crc_step <= 1'b0;
		end
		else
		begin
			flash_rd <= 1'b0;
			ev_done <= 1'b0;
			ev_fail <= 1'b0;
			crc_clear <= 1'b0;
			crc_step <= 1'b0;
			strobe_pending <= 1'b0;
			if (init_pending)
			begin
				// Reset-time configuration is caught after release, not in the reset branch
				init_pending <= 1'b0;
				if (boot_scan_en && boot_scan_src != `FIS_SEC_RESERVED)
				begin
					scan_en <= 1'b1;
					access_mode <= `FIS_MODE_FROM_BOOT;
					flash_section_select <= boot_scan_src;
					pass_flag <= 1'b0;
					crc_clear <= 1'b1;
					flash_addr <= {AW{1'b0}};
					state <= ST_RUN;
				end
			end
			else if (strobe_pending)
			begin
				// Enable for NMI survives the strobe; only system reset clears it
				state <= ST_IDLE;
				scan_en <= 1'b0;
				access_mode <= 2'h0;
				flash_section_select <= 2'h0;
				pass_flag <= 1'b0;
			end
			else
			begin
				if (wr_src && !busy && !locked)
				begin
					access_mode <= pwdata[`FIS_MODE_MSB:`FIS_MODE_LSB];
					flash_section_select <= pwdata[`FIS_SEC_MSB:`FIS_SEC_LSB];
				end
				if (wr_main && !locked)
				begin
					if (pwdata[`FIS_BIT_STROBE_RST] && (!nonmaskable_trigger_enable || !busy))
						strobe_pending <= 1'b1;
					if (pwdata[`FIS_BIT_NONMASKABLE_TRIGGER_ENABLE] && !busy)
						nonmaskable_trigger_enable <= 1'b1;
					// Clearing enable lets an ongoing scan run to its end
					scan_en <= pwdata[`FIS_BIT_EN];
					if (pwdata[`FIS_BIT_EN] && state == ST_IDLE)
					begin
						pass_flag <= 1'b0;
						delay_cnt <= `FIS_START_DELAY - 2'h1;
						state <= ST_DELAY;
					end
				end
				case (state)
					ST_IDLE:
					begin
					end
					ST_DELAY:
					begin
						if (delay_cnt != 2'h0)
							delay_cnt <= delay_cnt - 2'h1;
						else if (start_ok)
						begin
							crc_clear <= 1'b1;
							flash_addr <= {AW{1'b0}};
							state <= ST_RUN;
						end
						else
							state <= ST_IDLE;
					end
					ST_RUN:
					begin
						if (phase == PH_ISSUE)
							flash_rd <= 1'b1;
						else if (phase == PH_TAKE)
						begin
							if (flash_addr == last_addr)
							begin
								// Last word of the section holds the expected checksum
								state <= ST_IDLE;
								if (flash_rdata == crc_value)
								begin
									pass_flag <= 1'b1;
									ev_done <= 1'b1;
								end
								else
								begin
									ev_fail <= 1'b1;
									if (nonmaskable_trigger_enable)
										nmi_req <= 1'b1;
								end
							end
							else
							begin
								crc_step <= 1'b1;
								flash_addr <= flash_addr + {{(AW-1){1'b0}}, 1'b1};
							end
						end
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask

	assign int_events = {ev_fail, ev_done};
	assign int_clear = wr_int_st ? pwdata[1:0] : 2'h0;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_status <= 2'h0;
			int_mask <= 2'h0;
		end
		else
		begin
			// A new event outweighs a clear in the same cycle
			int_status <= (int_status & ~int_clear) | int_events;
			if (wr_mask)
				int_mask <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Datapath helpers

	// crc_step lags the take phase by one cycle, so the word is held in a register
	reg [15:0] take_word;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			take_word <= 16'h0000;
		else if (busy && phase == PH_TAKE)
			take_word <= flash_rdata;
	end

	fis_crc16 #(.POLY(`FIS_CRC_POLY), .INIT(`FIS_CRC_INIT)) u_crc (
		.pclk(pclk),
		.presetn(presetn),
		.clear(crc_clear),
		.step(crc_step),
		.word(take_word),
		.crc(crc_value)
	);

	fis_divider #(.N(`FIS_FETCH_PERIOD), .W(2)) u_pace (
		.pclk(pclk),
		.presetn(presetn),
		.run(busy),
		.phase(phase)
	);

endmodule

`default_nettype wire

//--- testbench/fis_flash_model.sv
// Flash array model for the scanner, checksum stored at each section end
`default_nettype none
module fis_flash_model (
	// Fetch side
	input wire logic pclk,
	input wire logic flash_rd,
	input wire logic [14:0] flash_addr,
	output logic [15:0] flash_rdata,
	// Test control
	input wire logic bad,
	output logic [14:0] last_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:7];
	logic [15:0] c;
	////////////////////////////////////////
	initial
	begin
		c = 16'hffff;
		flash_rdata = 16'h0000;
		last_addr = 15'h0000;
		for (int i = 0; i < 8; i++)
		begin
			mem[i] = (i % 2 == 1 && i > 1) ? c : 16'h1234 * (i + 1);
			for (int b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h1021 : 16'h0000);
		end
	end
	// Word valid only in the cycle after the request; otherwise it keeps toggling
	always @(posedge pclk)
		if (flash_rd)
		begin
			flash_rdata <= mem[flash_addr[2:0]] ^ {15'h0000, bad};
			last_addr <= flash_addr;
		end
		else
			flash_rdata <= ~flash_rdata;
endmodule
`default_nettype wire

//--- testbench/fis_scan_sva.sv
// Port-level checks of the flash integrity scanner
`default_nettype none
module fis_scan_sva #(
	parameter AW = 15
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// Flash and system
	input wire logic flash_rd,
	input wire logic [AW-1:0] flash_addr,
	input wire logic cpu_halt,
	input wire logic nmi_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_en_write;
		psel && penable && pwrite && pstrb[0] && paddr == 12'h000 && pwdata[0] && !cpu_halt && !nmi_req;
	endsequence
	sequence s_wait3;
		!cpu_halt [*3];
	endsequence
	////////////////////////////////////////
	chk_start_delay: assert property (s_en_write |=> s_wait3)
		else $error("scan began before three cycles");
	chk_halt_fetch: assert property (flash_rd |-> cpu_halt || $past(cpu_halt))
		else $error("fetch without cpu halt");
	chk_fetch_gap: assert property (flash_rd |=> !flash_rd [*2])
		else $error("fetches closer than three cycles");
	chk_fetch_next: assert property (flash_rd |-> ##3
		(flash_rd && flash_addr == $past(flash_addr, 3) + 1'b1 || !cpu_halt))
		else $error("fetch pace or address step wrong");
	chk_first_fetch: assert property ($rose(cpu_halt) |-> ##[0:2]
		(flash_rd && flash_addr == '0))
		else $error("scan did not start at word zero");
	chk_nmi_hold: assert property (nmi_req |=> nmi_req)
		else $error("nmi request dropped");
	chk_nmi_cause: assert property ($rose(nmi_req) |-> $fell(cpu_halt))
		else $error("nmi not at scan end");
	chk_busy_read: assert property (psel && !penable && !pwrite && paddr == 12'h008
		&& cpu_halt |=> prdata[1:0] == 2'b01)
		else $error("busy scan status wrong");
endmodule
bind fis_flash_integrity_scanner fis_scan_sva #(.AW(AW)) u_sva (.pclk, .presetn, .paddr,
	.psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .flash_rd, .flash_addr, .cpu_halt,
	.nmi_req);
`default_nettype wire

//--- testbench/fis_flash_integrity_scanner_tb.sv
// Register-level test of the flash integrity scanner
`default_nettype none
module fis_flash_integrity_scanner_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad = 0, ben = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [14:0] fa, top;
	logic [15:0] fd;
	logic [1:0] bsrc = 2'h2;
	logic pready, pslverr, frd, halt, nmi, irq, err;
	logic [7:0] rd;
	int bad_count = 0, compares = 0, cyc = 0;
	fis_flash_integrity_scanner dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .flash_rd(frd), .flash_addr(fa),
		.flash_rdata(fd), .boot_last_word(15'h0003), .app_last_word(15'h0005),
		.flash_last_word(15'h0007), .boot_scan_en(ben), .boot_scan_src(bsrc),
		.cpu_halt(halt), .nmi_req(nmi), .irq);
	fis_flash_model flash (.pclk, .flash_rd(frd), .flash_addr(fa), .flash_rdata(fd), .bad,
		.last_addr(top));
	////////////////////////////////////////
	initial
		forever #20 pclk = ~pclk;
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// Outputs are looked at once settled, away from the edge that launches them
		@(negedge pclk);
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input logic [9:0] i, input logic [7:0] e, input string n);
		apb(0, i, 8'h00);
		chk(n, e, rd);
	endtask
	task automatic scan(input logic [7:0] s, input logic [7:0] c);
		apb(1, 1, s);
		apb(1, 0, c);
	endtask
	// Polls the halt pin rather than counting, since scan length depends on section
	task automatic wait_idle;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		while (halt !== 1'b0) @(negedge pclk);
	endtask
	task automatic rst(input logic e);
		@(posedge pclk);
		ben <= e;
		presetn <= 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
	endtask
	task conclude;
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			conclude();
		end
	end
	////////////////////////////////////////
	initial
	begin
		rst(1);
		rdchk(2, 8'h01, "boot busy");
		rdchk(1, 8'h12, "boot src");
		wait_idle();
		rdchk(2, 8'h02, "boot pass");
		chk("boot end", 8'h03, top[7:0]);
		apb(1, 1, 8'h00);
		rdchk(1, 8'h00, "mode rewrite");
		chk("irq masked", 8'h00, {7'h0, irq});
		apb(1, 4, 8'h01);
		chk("irq", 8'h01, {7'h0, irq});
		apb(1, 3, 8'h01);
		rdchk(3, 8'h00, "w1c");
		chk("irq clear", 8'h00, {7'h0, irq});
		rst(0);
		rdchk(2, 8'h02, "result reset");
		rdchk(1, 8'h00, "src reset");
		apb(1, 2, 8'hff);
		rdchk(2, 8'h02, "result ro");
		for (int s = 0; s < 3; s++)
		begin
			scan(s[7:0], 8'h01);
			repeat (4) @(posedge pclk);
			rdchk(2, 8'h01, "busy");
			apb(1, 1, 8'h33);
			rdchk(1, s[7:0], "src lock");
			wait_idle();
			rdchk(2, 8'h02, "pass");
			chk("section end", 8'(7 - 2 * s), top[7:0]);
		end
		rdchk(2, 8'h02, "still good");
		// Reserved section, then every non-priority mode code
		for (int i = 0; i < 4; i++)
		begin
			scan(i == 0 ? 8'h03 : {2'h0, i[1:0], 4'h0}, 8'h01);
			repeat (6) @(posedge pclk);
			chk("no scan", 8'h00, {7'h0, halt});
			rdchk(2, 8'h00, "no pass");
		end
		scan(8'h01, 8'h01);
		repeat (6) @(posedge pclk);
		apb(1, 0, 8'h80);
		rdchk(2, 8'h00, "strobe result");
		rdchk(1, 8'h00, "strobe src");
		rdchk(0, 8'h00, "strobe ctrl");
		bad <= 1;
		apb(1, 4, 8'h02);
		scan(8'h02, 8'h03);
		wait_idle();
		rdchk(2, 8'h00, "fail");
		chk("nmi", 8'h01, {7'h0, nmi});
		chk("irq fail", 8'h01, {7'h0, irq});
		apb(1, 1, 8'h01);
		rdchk(1, 8'h02, "nmi lock");
		apb(1, 3, 8'h03);
		chk("irq w1c", 8'h00, {7'h0, irq});
		rdchk(5, 8'h00, "unmapped");
		chk("slverr", 8'h01, {7'h0, err});
		chk("ready", 8'h01, {7'h0, pready});
		chk("nmi held", 8'h01, {7'h0, nmi});
		conclude();
	end
endmodule
`default_nettype wire
